// *** hdl/dram_ctl_pkg.sv ***
package dram_ctl_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 10;
  localparam int ROW_W       = 9;
  localparam int ROWS        = 512;
  localparam int INIT_CYCLES = 8;

  // ---------------------------------------------------------------
  // timing, ns at 100 MHz, power-up and refresh in us
  // ---------------------------------------------------------------
  localparam int CLK_NS       = 10;
  localparam int T_ROW_LOW_NS = 70;   // row strobe pulse width
  localparam int T_ROW_PRE_NS = 60;   // row strobe precharge
  localparam int T_ROW_COL_NS = 20;   // row to column strobe delay
  localparam int T_COL_LOW_NS = 25;   // column strobe pulse width
  localparam int T_RD_HOLD_NS = 0;    // read_hold_after_row_rise / column
  localparam int T_CBR_SU_NS  = 10;   // column_before_row_setup, kept positive
  localparam int T_CBR_HLD_NS = 15;
  localparam int T_WR_HOLD_NS = 15;
  localparam int T_PWRUP_US   = 200;
  localparam int T_REFRESH_US = 8200; // refresh_interval 8.2 ms

  function automatic int cyc_min(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS < 1 ? 1 : (ns + CLK_NS - 1) / CLK_NS;
  endfunction : cyc_min

  localparam int C_ROW_LOW = cyc_min(T_ROW_LOW_NS);
  localparam int C_ROW_PRE = cyc_min(T_ROW_PRE_NS);
  localparam int C_ROW_COL = cyc_min(T_ROW_COL_NS);
  localparam int C_COL_LOW = cyc_min(T_COL_LOW_NS);
  localparam int C_RD_HOLD = cyc_min(T_RD_HOLD_NS);
  localparam int C_CBR_SU  = cyc_min(T_CBR_SU_NS);
  localparam int C_CBR_HLD = cyc_min(T_CBR_HLD_NS);
  localparam int C_WR_HOLD = cyc_min(T_WR_HOLD_NS);
  localparam int C_PWRUP   = T_PWRUP_US * 1000 / CLK_NS;
  // refresh one row per interval/rows, rounded down so the array is met early
  localparam int C_REF_ROW = T_REFRESH_US * 1000 / CLK_NS / ROWS;

  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_RMW,
    OP_NIB_READ
  } op_e;

  typedef struct packed {
    op_e                op;
    logic [19:0]        addr;
    logic               wdata;
  } req_s;

  typedef struct packed {
    logic               row_n;
    logic               col_n;
    logic               we_n;
    logic [ADDR_W-1:0]  addr;
    logic               din;
  } pins_s;
endpackage : dram_ctl_pkg

// *** hdl/sync2.sv ***
`timescale 1ns/1ps
module sync2 (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : sync2

// *** hdl/dram_ctl.sv ***
`timescale 1ns/1ps
// How it works
// - row address on pins at row strobe fall, column address at column fall
// - reads keep row and column strobes low, write strobe high throughout
// - write strobe stays high past read hold after strobes rise
// - row-only refresh: row low, column high, row address presented
// - column low before row fall triggers internal counter refresh
// - every one of 512 rows refreshed within 8.2 ms
// - power-up pause 200 us, then eight refresh cycles
// - nibble accesses never count as refreshing a row
// - nibble mode steps column by column strobe falling, row held low
module dram_ctl
  import dram_ctl_pkg::*;
#(
  parameter int PWRUP_CYC  = C_PWRUP,
  parameter int REFROW_CYC = C_REF_ROW,
  parameter bit USE_CBR    = 1'b0
) (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire dram_ctl_pkg::req_s  req_i,
  input  wire logic                req_valid_i,
  output logic                     req_ready_o,
  output logic                     rdata_o,
  output logic                     rdata_valid_o,
  output logic                     init_done_o,
  output dram_ctl_pkg::pins_s      pins_o,
  input  wire logic                dout_i
);
  import dram_ctl_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_PWRUP, S_IDLE, S_RAS, S_CAS, S_WE, S_NIB_PRE, S_END, S_PRE,
    S_REF_SU, S_REF_LOW
  } st_e;

  typedef struct packed {
    st_e               st;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  ref_tmr;
    logic [ROW_W-1:0]  ref_row;
    logic [3:0]        ref_owed;
    logic [3:0]        init_left;
    logic              init_done;
    logic              ref_cbr;
    req_s              req;
    logic [1:0]        nib;
    logic              ready;
    logic              rdata;
    logic              rvalid;
    pins_s             pins;
  } ctl_s;

  ctl_s s_r, s_nxt;
  logic dout_s;

  sync2 u_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    (dout_i),
    .q_o    (dout_s)
  );

  // read sample lands late enough for the two-flop delay on the pin
  localparam int C_SAMPLE = C_COL_LOW + 2;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.ready  = 1'b0;
    s_nxt.cnt    = s_r.cnt + CNT_W'(1);
    // row timer runs once init is done; owed count saturates
    if (s_r.init_done) begin
      if (s_r.ref_tmr >= CNT_W'(REFROW_CYC - 1)) begin
        s_nxt.ref_tmr = '0;
        if (s_r.ref_owed != 4'hF) s_nxt.ref_owed = s_r.ref_owed + 4'h1;
      end else begin
        s_nxt.ref_tmr = s_r.ref_tmr + CNT_W'(1);
      end
    end
    case (s_r.st)
      S_PWRUP: begin
        s_nxt.pins.row_n = 1'b1;
        s_nxt.pins.col_n = 1'b1;
        if (s_r.cnt >= CNT_W'(PWRUP_CYC - 1)) begin
          s_nxt.cnt     = '0;
          s_nxt.ref_cbr = USE_CBR;
          s_nxt.st      = USE_CBR ? S_REF_SU : S_REF_LOW;
        end
      end
      S_IDLE: begin
        s_nxt.cnt = '0;
        s_nxt.pins.row_n = 1'b1;
        s_nxt.pins.col_n = 1'b1;
        s_nxt.pins.we_n  = 1'b1;
        // init refreshes also leave from idle, so requests wait until they are done
        if (!s_r.init_done || s_r.ref_owed != 4'h0) begin
          s_nxt.ref_cbr = USE_CBR;
          s_nxt.st      = USE_CBR ? S_REF_SU : S_REF_LOW;
          s_nxt.pins.addr = ADDR_W'(s_r.ref_row);
        end else if (req_valid_i) begin
          s_nxt.req   = req_i;
          s_nxt.ready = 1'b1;
          s_nxt.pins.addr = req_i.addr[19:10];
          s_nxt.st    = S_RAS;
        end
      end
      S_RAS: begin
        s_nxt.pins.row_n = 1'b0;
        // early write: write strobe low before column fall
        s_nxt.pins.we_n  = (s_r.req.op == OP_WRITE) ? 1'b0 : 1'b1;
        s_nxt.pins.din   = s_r.req.wdata;
        if (s_r.cnt >= CNT_W'(C_ROW_COL)) begin
          s_nxt.pins.addr = s_r.req.addr[9:0];
          s_nxt.cnt = '0;
          s_nxt.nib = '0;
          s_nxt.st  = S_CAS;
        end
      end
      S_CAS: begin
        s_nxt.pins.col_n = 1'b0;
        if (s_r.cnt == CNT_W'(C_SAMPLE) && s_r.req.op != OP_WRITE) begin
          s_nxt.rdata  = dout_s;
          s_nxt.rvalid = 1'b1;
        end
        if (s_r.cnt >= CNT_W'(C_SAMPLE)) begin
          s_nxt.cnt = '0;
          if (s_r.req.op == OP_RMW) begin
            s_nxt.st = S_WE;
          end else if (s_r.req.op == OP_NIB_READ && s_r.nib != 2'h3) begin
            s_nxt.st = S_NIB_PRE;
          end else begin
            s_nxt.st = S_END;
          end
        end
      end
      S_WE: begin
        // write strobe falls well after column, row and address delays
        s_nxt.pins.we_n = 1'b0;
        if (s_r.cnt >= CNT_W'(C_WR_HOLD)) begin
          s_nxt.cnt = '0;
          s_nxt.st  = S_END;
        end
      end
      S_NIB_PRE: begin
        s_nxt.pins.col_n = 1'b1;
        if (s_r.cnt >= CNT_W'(C_CBR_SU - 1)) begin
          s_nxt.cnt = '0;
          s_nxt.nib = s_r.nib + 2'h1;
          s_nxt.st  = S_CAS;
        end
      end
      S_END: begin
        // both strobes rise together; write strobe held for read hold
        s_nxt.pins.row_n = 1'b1;
        s_nxt.pins.col_n = 1'b1;
        if (s_r.cnt >= CNT_W'(C_RD_HOLD)) begin
          s_nxt.pins.we_n = 1'b1;
          s_nxt.cnt = '0;
          s_nxt.st  = S_PRE;
        end
      end
      S_PRE: begin
        s_nxt.pins.we_n = 1'b1;
        if (s_r.cnt >= CNT_W'(C_ROW_PRE - 1)) begin
          s_nxt.cnt = '0;
          s_nxt.st  = S_IDLE;
        end
      end
      S_REF_SU: begin
        s_nxt.pins.col_n = 1'b0;
        if (s_r.cnt >= CNT_W'(C_CBR_SU - 1)) begin
          s_nxt.cnt = '0;
          s_nxt.st  = S_REF_LOW;
        end
      end
      S_REF_LOW: begin
        s_nxt.pins.row_n = 1'b0;
        if (!s_r.ref_cbr) s_nxt.pins.col_n = 1'b1;
        if (s_r.ref_cbr && s_r.cnt >= CNT_W'(C_CBR_HLD)) s_nxt.pins.col_n = 1'b1;
        // row strobe falls one edge after entry, so the full count keeps the pulse wide
        if (s_r.cnt >= CNT_W'(C_ROW_LOW)) begin
          s_nxt.cnt = '0;
          s_nxt.pins.row_n = 1'b1;
          s_nxt.pins.col_n = 1'b1;
          s_nxt.st = S_PRE;
          s_nxt.ref_row = s_r.ref_row + ROW_W'(1);
          if (!s_r.init_done) begin
            s_nxt.init_left = s_r.init_left - 4'h1;
            if (s_r.init_left == 4'h1) s_nxt.init_done = 1'b1;
          end else if (s_r.ref_owed != 4'h0) begin
            s_nxt.ref_owed = s_nxt.ref_owed - 4'h1;
          end
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_r            <= '0;
      s_r.st         <= S_PWRUP;
      s_r.init_left  <= 4'(INIT_CYCLES);
      s_r.pins.row_n <= 1'b1;
      s_r.pins.col_n <= 1'b1;
      s_r.pins.we_n  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign req_ready_o   = s_r.ready;
  assign rdata_o       = s_r.rdata;
  assign rdata_valid_o = s_r.rvalid;
  assign init_done_o   = s_r.init_done;
  assign pins_o        = s_r.pins;
endmodule : dram_ctl

// *** verif/dram_ctl_monitor.sv ***
`timescale 1ns/1ps
module dram_ctl_monitor
  import dram_ctl_pkg::*;
#(
  parameter int PWRUP_CYC  = 20,
  parameter int REFROW_CYC = 50,
  parameter bit USE_CBR    = 1'b0
) (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire dram_ctl_pkg::req_s  req_i,
  input  wire logic                req_valid_i,
  input  wire logic                req_ready_o,
  input  wire logic                rdata_o,
  input  wire logic                rdata_valid_o,
  input  wire logic                init_done_o,
  input  wire dram_ctl_pkg::pins_s pins_o,
  input  wire logic                dout_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // idle time of the row strobe, the refresh timer must cut it short
  logic [15:0] hi_cnt_r;
  always_ff @(posedge clk_i) begin
    hi_cnt_r <= (srst_i || !pins_o.row_n) ? 16'h0 : hi_cnt_r + 16'h1;
  end
  chk_reset_idle: assert property ($fell(srst_i) |-> pins_o.row_n && pins_o.col_n
    && !init_done_o) else $error("strobes active after reset");
  chk_init_gate: assert property (!init_done_o |-> !req_ready_o)
    else $error("request taken before init");
  chk_col_after_row: assert property ($fell(pins_o.col_n) && !USE_CBR |-> !pins_o.row_n)
    else $error("column strobe before row strobe");
  chk_row_addr_set: assert property ($fell(pins_o.row_n) |-> $stable(pins_o.addr))
    else $error("address moves at row strobe fall");
  chk_row_width: assert property ($fell(pins_o.row_n) |=> !pins_o.row_n [*6])
    else $error("row strobe pulse too short");
  chk_read_we_high: assert property ($fell(pins_o.col_n) && pins_o.we_n && !pins_o.row_n
    |=> pins_o.we_n [*2]) else $error("write strobe drops in read");
  chk_din_setup: assert property ($fell(pins_o.col_n) && !pins_o.we_n
    |-> $stable(pins_o.din)) else $error("data moves at capture edge");
  chk_read_answer: assert property (req_ready_o && req_i.op == OP_READ
    |-> ##[2:16] rdata_valid_o) else $error("read data missing");
  chk_write_quiet: assert property (req_ready_o && req_i.op == OP_WRITE
    |=> !rdata_valid_o [*8]) else $error("read data after write");
  chk_refresh_due: assert property (init_done_o |-> hi_cnt_r <= REFROW_CYC + 16)
    else $error("refresh overdue");
  cover property (req_ready_o && req_i.op == OP_RMW);
  cover property (req_ready_o && req_i.op == OP_NIB_READ);
  cover property ($fell(pins_o.row_n) && pins_o.col_n);
endmodule : dram_ctl_monitor

bind dram_ctl dram_ctl_monitor #(
  .PWRUP_CYC(PWRUP_CYC), .REFROW_CYC(REFROW_CYC), .USE_CBR(USE_CBR)
) u_mon (.clk_i(clk_i), .srst_i(srst_i), .req_i(req_i), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
  .init_done_o(init_done_o), .pins_o(pins_o), .dout_i(dout_i));

// *** verif/dram_model.sv ***
`timescale 1ns/1ps
module dram_model (
  input  wire logic       row_n_i,
  input  wire logic       col_n_i,
  input  wire logic       we_n_i,
  input  wire logic [9:0] addr_i,
  input  wire logic       din_i,
  output logic            dout_o
);
  // only five row and five column bits kept, tests avoid aliases
  logic       mem [0:1023] = '{default: 1'h0};
  logic [9:0] row_r;
  logic [9:0] col_r;
  logic       q_r     = 1'h0;
  logic       oe_r    = 1'h0;
  logic       first_r = 1'h0;
  int         ref_cnt = 0;
  always @(negedge row_n_i) begin
    row_r   = addr_i;
    first_r = 1'h1;
    if (!col_n_i)
      ref_cnt = ref_cnt + 1;
  end
  always @(negedge col_n_i) if (!row_n_i) begin
    col_r   = first_r ? addr_i : {col_r[9:2], col_r[1:0] + 2'h1};
    first_r = 1'h0;
    q_r     = mem[{row_r[4:0], col_r[4:0]}];
    oe_r    = we_n_i;
    if (!we_n_i)
      mem[{row_r[4:0], col_r[4:0]}] = din_i;
  end
  always @(negedge we_n_i) if (!row_n_i && !col_n_i) begin
    mem[{row_r[4:0], col_r[4:0]}] = din_i;
  end
  always @(posedge col_n_i) oe_r = 1'h0;
  // released output shows the inverse, never the last bit
  assign dout_o = oe_r ? q_r : ~q_r;
endmodule : dram_model

// *** verif/tb_dram_ctl.sv ***
`timescale 1ns/1ps
module tb_dram_ctl;
  import dram_ctl_pkg::*;
  typedef struct packed {op_e op; logic [19:0] a; logic wd; logic ex;} vec_s;
  localparam vec_s VEC [10] = '{'{OP_WRITE, 20'h00C05, 1'h1, 1'h0},
    '{OP_WRITE, 20'h00C06, 1'h0, 1'h0}, '{OP_READ, 20'h00C05, 1'h0, 1'h1},
    '{OP_READ, 20'h00C06, 1'h0, 1'h0}, '{OP_RMW, 20'h00C05, 1'h0, 1'h1},
    '{OP_READ, 20'h00C05, 1'h0, 1'h0}, '{OP_WRITE, 20'h01400, 1'h1, 1'h0},
    '{OP_WRITE, 20'h01401, 1'h0, 1'h0}, '{OP_WRITE, 20'h01402, 1'h1, 1'h0},
    '{OP_WRITE, 20'h01403, 1'h1, 1'h0}};
  logic  clk_i       = 1'h0;
  logic  srst_i      = 1'h1;
  req_s  req_i       = '0;
  logic  req_valid_i = 1'h0;
  logic  req_ready_o, rdata_o, rdata_valid_o, init_done_o, dout_i;
  pins_s pins_o;
  logic  got [4];
  logic  col_seen    = 1'h0;
  int    fails       = 0;
  int    num_checks  = 0;
  int    refs        = 0;
  int    r0;
  always #5 clk_i = ~clk_i;
  dram_ctl #(.PWRUP_CYC(20), .REFROW_CYC(50), .USE_CBR(1'b0)) dut (.clk_i(clk_i),
    .srst_i(srst_i), .req_i(req_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .init_done_o(init_done_o),
    .pins_o(pins_o), .dout_i(dout_i));
  dram_model u_dev (.row_n_i(pins_o.row_n), .col_n_i(pins_o.col_n), .we_n_i(pins_o.we_n),
    .addr_i(pins_o.addr), .din_i(pins_o.din), .dout_o(dout_i));
  // a row cycle without a column strobe is a row-only refresh
  always @(negedge pins_o.col_n) col_seen = 1'h1;
  always @(posedge pins_o.row_n) begin
    if (!col_seen)
      refs++;
    col_seen = 1'h0;
  end
  task automatic chk(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic access(input op_e op, input logic [19:0] a, input logic wd, input int n);
    int k;
    // let an edge pass so the valid just dropped is never raised in the same step
    @(negedge clk_i);
    req_i       = '{op, a, wd};
    req_valid_i = 1'h1;
    k = 0;
    while (req_ready_o !== 1'h1 && k < 500) begin
      @(negedge clk_i);
      k++;
    end
    req_valid_i = 1'h0;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(negedge clk_i);
        k++;
      end while (rdata_valid_o !== 1'h1 && k < 40);
      got[i] = (k < 40) ? rdata_o : 1'hx;
    end
  endtask : access
  task automatic test_done;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (12) @(negedge clk_i);
    srst_i = 1'h0;
    r0 = refs;
    chk(pins_o.row_n & pins_o.col_n & ~init_done_o, 1'h1);
    foreach (VEC[i]) begin
      access(VEC[i].op, VEC[i].a, VEC[i].wd, (VEC[i].op == OP_WRITE) ? 0 : 1);
      if (i == 0)
        chk(refs - r0 >= 8 && refs - r0 <= 9, 1'h1);
      if (i == 0)
        chk(init_done_o, 1'h1);
      if (VEC[i].op != OP_WRITE)
        chk(got[0], VEC[i].ex);
      $display("access %0d done", i);
    end
    access(OP_NIB_READ, 20'h01400, 1'h0, 4);
    foreach (got[i]) chk(got[i], VEC[6 + i].wd);
    $display("nibble done");
    r0 = refs;
    repeat (160) @(negedge clk_i);
    chk(refs - r0 >= 2, 1'h1);
    $display("refresh done");
    srst_i = 1'h1;
    repeat (2) @(negedge clk_i);
    chk(pins_o.row_n & pins_o.col_n & ~init_done_o, 1'h1);
    srst_i = 1'h0;
    access(OP_READ, 20'h01400, 1'h0, 1);
    chk(got[0], 1'h1);
    $display("second reset done");
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    test_done();
  end
endmodule : tb_dram_ctl
